// *** pkg/slcr_defs.vh ***
// Addresses, field positions, reset values and codes of the strap registers
`ifndef SLCR_DEFS_VH
`define SLCR_DEFS_VH

`define SLCR_SYS_ADDR      32'hFEF80400
`define SLCR_MEM_ADDR      32'hFEF80404
`define SLCR_CFG_RST       32'hFFFFFFFF
`define SLCR_RD_ZERO       32'h00000000

`define SLCR_ID_MSB        31
`define SLCR_ID_LSB        24
`define SLCR_CLK_MSB       23
`define SLCR_CLK_LSB       20
`define SLCR_XC_MSB        19
`define SLCR_XC_LSB        16
`define SLCR_P0_MSB        15
`define SLCR_P0_LSB        12
`define SLCR_P1_MSB        11
`define SLCR_P1_LSB        8
`define SLCR_LOW_MSB       15

`define SLCR_SIZE_MSB      31
`define SLCR_SIZE_LSB      30
`define SLCR_FREF_BIT      28
`define SLCR_SPD_MSB       25
`define SLCR_SPD_LSB       24
`define SLCR_RA_MSB        22
`define SLCR_RA_LSB        20
`define SLCR_RB_MSB        18
`define SLCR_RB_LSB        16
`define SLCR_L2T_MSB       15
`define SLCR_L2T_LSB       12
`define SLCR_L2P_MSB       11
`define SLCR_L2P_LSB       8
`define SLCR_FLA_MSB       5
`define SLCR_FLA_LSB       3

`define SLCR_XC_NONE       4'hF
`define SLCR_CLK_FIRST_OK  4'hD
`define SLCR_CLK_50        4'hD
`define SLCR_CLK_60        4'hE
`define SLCR_CLK_66        4'hF
`define SLCR_CPU_FIRST_OK  4'h4
`define SLCR_CPU_ABSENT    4'h8
`define SLCR_MEM_BASE_MB   8'h10
`define SLCR_SPD_70        2'h0
`define SLCR_SPD_60        2'h1
`define SLCR_SPD_RSVD      2'h2
`define SLCR_SPD_EDO       2'h3
`define SLCR_ROM_FLASH16   3'h6
`define SLCR_ROM_UNKNOWN   3'h7
`define SLCR_L2T_FIRST_RSV 4'h2
`define SLCR_L2P_OFF       4'h0
`define SLCR_L2P_MAX       4'h5
`define SLCR_FLA_NONE      3'h7
`define SLCR_FLA_BASE_MB   7'h01

`endif

// *** src/slcr_sync2.v ***
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps

module slcr_sync2 #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
)(
	mclk,
	arst_n,
	ce,
	din,
	dout
);
	input  wire             mclk;
	input  wire             arst_n;
	input  wire             ce;
	input  wire [WIDTH-1:0] din;
	output wire [WIDTH-1:0] dout;

	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			always @(posedge mclk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					meta_r[i] <= RST_VAL[i];
					sync_r[i] <= RST_VAL[i];
				end
				else if (ce)
				begin
					meta_r[i] <= din[i];
					sync_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate

	assign dout = sync_r;
endmodule

// *** src/slcr_top.v ***
// Strap-latched system and memory configuration registers
`timescale 1ns/1ps
`include "slcr_defs.vh"

// How it works
// - System pins are captured on the power-up reset rising edge and held.
// - Bits default to one; only a board pull-down makes a zero.
// - The system register is 32 bits wide and read-only.
// - Memory pins are captured on the same edge into a separate 32-bit read-only register.
// - The identity field returns a fixed system-type code.
// - Clock code D/E/F give 50/25, 60/30, 66.66/33.33 MHz; lower reserved.
// - The external cache field always reads 1111, no external cache.
// - Processor code 4..7 present with cache size; 8 up absent; low reserved.
// - Memory size code 0..3 means 16, 32, 64, 128 megabytes.
// - Fast-refresh set means software must raise the refresh rate.
// - Speed code 0 is 70ns, 1 is 60ns, 3 is 50ns EDO, 2 reserved.
// - ROM code 110 is 16-bit flash, 111 unknown, lower codes reserved.
// - Second_level_memory_type 0 late-write, 1 pipelined burst, 2 upward reserved.
// - The block decodes its own register port for these registers.
// - L2 divider 0 disabled, 1..5 ratios 1 to 3, higher reserved.
// - Bank A flash size 1MB doubling to 64MB; 111 means none.
module slcr_top #(
	parameter [7:0] SYSTEM_ID = 8'h5A
)(
	mclk,
	arst_n,
	ce,
	por_n,
	sys_pin,
	mem_pin,
	reg_sel,
	reg_wr,
	reg_addr,
	reg_wdata,
	reg_rdata,
	reg_ack,
	reg_err,
	cfg_valid,
	clk_code_reserved,
	cpu0_present,
	cpu1_present,
	mem_size_mb,
	fast_refresh_flag,
	mem_speed_reserved,
	mem_speed_edo,
	rom_a_flash16,
	rom_b_flash16,
	second_level_memory_type_reserved,
	l2_div_enabled,
	l2_div_reserved,
	flash_a_size_mb,
	flash_a_absent
);
	input  wire        mclk;
	input  wire        arst_n;
	input  wire        ce;
	input  wire        por_n;
	input  wire [31:0] sys_pin;
	input  wire [31:0] mem_pin;
	input  wire        reg_sel;
	input  wire        reg_wr;
	input  wire [31:0] reg_addr;
	input  wire [31:0] reg_wdata;
	output wire [31:0] reg_rdata;
	output wire        reg_ack;
	output wire        reg_err;
	output wire        cfg_valid;
	output wire        clk_code_reserved;
	output wire        cpu0_present;
	output wire        cpu1_present;
	output wire [7:0]  mem_size_mb;
	output wire        fast_refresh_flag;
	output wire        mem_speed_reserved;
	output wire        mem_speed_edo;
	output wire        rom_a_flash16;
	output wire        rom_b_flash16;
	output wire        second_level_memory_type_reserved;
	output wire        l2_div_enabled;
	output wire        l2_div_reserved;
	output wire [6:0]  flash_a_size_mb;
	output wire        flash_a_absent;

	wire [31:0] sys_s;
	wire [31:0] mem_s;
	wire [0:0]  por_s;

	reg  [31:0] system_config_reg;
	reg  [31:0] memory_config_reg;
	reg         por_d_r;
	reg         valid_r;
	reg  [31:0] rdata_r;
	reg         ack_r;
	reg         err_r;
	reg  [31:0] rdata_nxt;
	reg         err_nxt;
	reg  [31:0] sys_view;

	reg         clk_rsv_r;
	reg         cpu0_r;
	reg         cpu1_r;
	reg  [7:0]  size_r;
	reg         fref_r;
	reg         spd_rsv_r;
	reg         spd_edo_r;
	reg         rom_a_r;
	reg         rom_b_r;
	reg         l2t_rsv_r;
	reg         l2p_en_r;
	reg         l2p_rsv_r;
	reg  [6:0]  fla_size_r;
	reg         fla_none_r;

	wire        capture;

	slcr_sync2 #(
		.WIDTH   (32),
		.RST_VAL (`SLCR_CFG_RST)
	) u_sys_sync (
		.mclk   (mclk),
		.arst_n (arst_n),
		.ce     (ce),
		.din    (sys_pin),
		.dout   (sys_s)
	);

	slcr_sync2 #(
		.WIDTH   (32),
		.RST_VAL (`SLCR_CFG_RST)
	) u_mem_sync (
		.mclk   (mclk),
		.arst_n (arst_n),
		.ce     (ce),
		.din    (mem_pin),
		.dout   (mem_s)
	);

	slcr_sync2 #(
		.WIDTH   (1),
		.RST_VAL (1'b0)
	) u_por_sync (
		.mclk   (mclk),
		.arst_n (arst_n),
		.ce     (ce),
		.din    (por_n),
		.dout   (por_s)
	);

	// Release edge of the power-up reset
	assign capture = por_s[0] & ~por_d_r;

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			por_d_r           <= 1'b0;
			valid_r           <= 1'b0;
			system_config_reg <= `SLCR_CFG_RST;
			memory_config_reg <= `SLCR_CFG_RST;
		end
		else if (ce)
		begin
			por_d_r <= por_s[0];
			// Only the strap edge loads; bus writes never reach here
			if (capture)
			begin
				system_config_reg <= sys_s;
				memory_config_reg <= mem_s;
				valid_r           <= 1'b1;
			end
		end
	end

	// Read view with hardwired identity and cache fields
	always @*
	begin
		sys_view = system_config_reg;
		sys_view[`SLCR_ID_MSB:`SLCR_ID_LSB] = SYSTEM_ID;
		sys_view[`SLCR_XC_MSB:`SLCR_XC_LSB] = `SLCR_XC_NONE;
	end

	// Address decode of the register port
	always @*
	begin
		rdata_nxt = `SLCR_RD_ZERO;
		err_nxt   = 1'b0;
		if (reg_addr == `SLCR_SYS_ADDR)
		begin
			if (!reg_wr)
				rdata_nxt = sys_view;
		end
		else if (reg_addr == `SLCR_MEM_ADDR)
		begin
			if (!reg_wr)
				rdata_nxt = memory_config_reg;
		end
		else
			err_nxt = 1'b1;
	end

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_r   <= 1'b0;
			err_r   <= 1'b0;
			rdata_r <= `SLCR_RD_ZERO;
		end
		else if (ce)
		begin
			// Writes are acknowledged but store nothing
			ack_r <= reg_sel;
			err_r <= reg_sel & err_nxt;
			if (reg_sel)
				rdata_r <= rdata_nxt;
		end
	end

	// Registered decodes of the latched fields
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			clk_rsv_r  <= 1'b0;
			cpu0_r     <= 1'b0;
			cpu1_r     <= 1'b0;
			size_r     <= `SLCR_MEM_BASE_MB;
			fref_r     <= 1'b0;
			spd_rsv_r  <= 1'b0;
			spd_edo_r  <= 1'b0;
			rom_a_r    <= 1'b0;
			rom_b_r    <= 1'b0;
			l2t_rsv_r  <= 1'b0;
			l2p_en_r   <= 1'b0;
			l2p_rsv_r  <= 1'b0;
			fla_size_r <= `SLCR_FLA_BASE_MB;
			fla_none_r <= 1'b0;
		end
		else if (ce)
		begin
			clk_rsv_r <= system_config_reg[`SLCR_CLK_MSB:`SLCR_CLK_LSB]
				< `SLCR_CLK_FIRST_OK;
			cpu0_r <= (system_config_reg[`SLCR_P0_MSB:`SLCR_P0_LSB]
				>= `SLCR_CPU_FIRST_OK) &&
				(system_config_reg[`SLCR_P0_MSB:`SLCR_P0_LSB]
				< `SLCR_CPU_ABSENT);
			cpu1_r <= (system_config_reg[`SLCR_P1_MSB:`SLCR_P1_LSB]
				>= `SLCR_CPU_FIRST_OK) &&
				(system_config_reg[`SLCR_P1_MSB:`SLCR_P1_LSB]
				< `SLCR_CPU_ABSENT);
			size_r <= `SLCR_MEM_BASE_MB <<
				memory_config_reg[`SLCR_SIZE_MSB:`SLCR_SIZE_LSB];
			fref_r <= memory_config_reg[`SLCR_FREF_BIT];
			spd_rsv_r <= memory_config_reg[`SLCR_SPD_MSB:`SLCR_SPD_LSB]
				== `SLCR_SPD_RSVD;
			spd_edo_r <= memory_config_reg[`SLCR_SPD_MSB:`SLCR_SPD_LSB]
				== `SLCR_SPD_EDO;
			rom_a_r <= memory_config_reg[`SLCR_RA_MSB:`SLCR_RA_LSB]
				== `SLCR_ROM_FLASH16;
			rom_b_r <= memory_config_reg[`SLCR_RB_MSB:`SLCR_RB_LSB]
				== `SLCR_ROM_FLASH16;
			l2t_rsv_r <= memory_config_reg[`SLCR_L2T_MSB:`SLCR_L2T_LSB]
				>= `SLCR_L2T_FIRST_RSV;
			l2p_en_r <= memory_config_reg[`SLCR_L2P_MSB:`SLCR_L2P_LSB]
				!= `SLCR_L2P_OFF;
			l2p_rsv_r <= memory_config_reg[`SLCR_L2P_MSB:`SLCR_L2P_LSB]
				> `SLCR_L2P_MAX;
			if (memory_config_reg[`SLCR_FLA_MSB:`SLCR_FLA_LSB]
				== `SLCR_FLA_NONE)
				fla_size_r <= 7'h00;
			else
				fla_size_r <= `SLCR_FLA_BASE_MB <<
					memory_config_reg[`SLCR_FLA_MSB:`SLCR_FLA_LSB];
			fla_none_r <= memory_config_reg[`SLCR_FLA_MSB:`SLCR_FLA_LSB]
				== `SLCR_FLA_NONE;
		end
	end

	assign reg_rdata          = rdata_r;
	assign reg_ack            = ack_r;
	assign reg_err            = err_r;
	assign cfg_valid          = valid_r;
	assign clk_code_reserved  = clk_rsv_r;
	assign cpu0_present       = cpu0_r;
	assign cpu1_present       = cpu1_r;
	assign mem_size_mb        = size_r;
	assign fast_refresh_flag  = fref_r;
	assign mem_speed_reserved = spd_rsv_r;
	assign mem_speed_edo      = spd_edo_r;
	assign rom_a_flash16      = rom_a_r;
	assign rom_b_flash16      = rom_b_r;
	assign second_level_memory_type_reserved   = l2t_rsv_r;
	assign l2_div_enabled     = l2p_en_r;
	assign l2_div_reserved    = l2p_rsv_r;
	assign flash_a_size_mb    = fla_size_r;
	assign flash_a_absent     = fla_none_r;
endmodule

// *** verif/slcr_strap_board.sv ***
// Board model: weak pull-ups on every strap pin, pull-downs where fitted
`timescale 1ns/1ps
module slcr_strap_board (
	input  logic [31:0] pd_sys,
	input  logic [31:0] pd_mem,
	output logic [31:0] sys_pin,
	output logic [31:0] mem_pin
);
	// A fitted pull-down wins over the weak pull-up
	assign sys_pin = ~pd_sys;
	assign mem_pin = ~pd_mem;
endmodule

// *** verif/slcr_monitor.sv ***
// Port checker for the strap configuration registers
`timescale 1ns/1ps
`include "slcr_defs.vh"
module slcr_monitor #(
	parameter [7:0] SYSTEM_ID = 8'h5A
)(
	input logic        mclk,
	input logic        arst_n,
	input logic        ce,
	input logic        por_n,
	input logic        reg_sel,
	input logic        reg_wr,
	input logic [31:0] reg_addr,
	input logic [31:0] reg_rdata,
	input logic        reg_ack,
	input logic        reg_err,
	input logic        cfg_valid,
	input logic [7:0]  mem_size_mb,
	input logic [6:0]  flash_a_size_mb,
	input logic        flash_a_absent
);
	logic req;
	logic hit;
	assign req = ce && reg_sel;
	assign hit = reg_addr == `SLCR_SYS_ADDR ||
		reg_addr == `SLCR_MEM_ADDR;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_ack_follows: assert property (req |=> reg_ack)
		else $error("ack missing");
	a_ack_cause: assert property (
		reg_ack && $past(ce) |-> $past(reg_sel))
		else $error("ack without request");
	a_unmapped_err: assert property (
		req && !hit |=> reg_err && reg_rdata == 32'h0)
		else $error("unmapped access not flagged");
	a_err_ack: assert property (reg_err |-> reg_ack)
		else $error("err without ack");
	a_write_ignored: assert property (
		req && reg_wr && hit |=> !reg_err && reg_rdata == 32'h0)
		else $error("write not ignored");
	a_sys_fixed: assert property (
		req && !reg_wr && reg_addr == `SLCR_SYS_ADDR
		|=> reg_rdata[31:24] == SYSTEM_ID && reg_rdata[19:16] == 4'hF)
		else $error("fixed system fields wrong");
	a_capture_soon: assert property (
		$rose(por_n) |-> ##[1:4] cfg_valid)
		else $error("capture late");
	a_valid_holds: assert property (cfg_valid |=> cfg_valid)
		else $error("valid dropped");
	a_rdata_holds: assert property (
		!$past(req) |-> $stable(reg_rdata))
		else $error("read data moved");
	a_flash_pair: assert property (
		flash_a_absent == (flash_a_size_mb == 7'h0))
		else $error("flash decode mismatch");
	a_size_legal: assert property (
		mem_size_mb inside {8'h10, 8'h20, 8'h40, 8'h80})
		else $error("memory size illegal");
endmodule

// *** verif/test_slcr_top.sv ***
// Self-checking bench for the strap configuration registers
`timescale 1ns/1ps
`include "slcr_defs.vh"
module test_slcr_top;
	localparam [7:0] SID = 8'hC3; // Arbitrary identity code
	logic        mclk, arst_n, ce, por_n, reg_sel, reg_wr;
	logic [31:0] reg_addr, reg_wdata, pd_sys, pd_mem, ps, pm, ls, lm, r;
	logic [3:0]  c;
	logic [32:0] q[$];
	wire  [31:0] sys_pin, mem_pin, reg_rdata;
	wire         reg_ack, reg_err, cfg_valid, clk_code_reserved, fref;
	wire         cpu0_present, cpu1_present, spd_rsv, spd_edo, fl_abs;
	wire         rom_a, rom_b, l2_rsv, l2_en, l2_div_rsv;
	wire  [7:0]  mem_size_mb;
	wire  [6:0]  flash_a_size_mb;
	integer      n_fail = 0, n_checks = 0, seed = 84, i;
	slcr_strap_board brd (.pd_sys(pd_sys), .pd_mem(pd_mem),
		.sys_pin(sys_pin), .mem_pin(mem_pin));
	slcr_top #(.SYSTEM_ID(SID)) dut (.mclk(mclk), .arst_n(arst_n), .ce(ce),
		.por_n(por_n), .sys_pin(sys_pin), .mem_pin(mem_pin),
		.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.reg_err(reg_err), .cfg_valid(cfg_valid),
		.clk_code_reserved(clk_code_reserved), .cpu0_present(cpu0_present),
		.cpu1_present(cpu1_present), .mem_size_mb(mem_size_mb),
		.fast_refresh_flag(fref), .mem_speed_reserved(spd_rsv),
		.mem_speed_edo(spd_edo), .rom_a_flash16(rom_a), .rom_b_flash16(rom_b),
		.second_level_memory_type_reserved(l2_rsv), .l2_div_enabled(l2_en),
		.l2_div_reserved(l2_div_rsv), .flash_a_size_mb(flash_a_size_mb),
		.flash_a_absent(fl_abs));
	initial
	begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	task chk(input logic [39:0] seen, input logic [39:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One access per call; a following call keeps the port busy back to back
	task acc(input logic w, input logic [31:0] a, input logic [32:0] e);
		@(negedge mclk);
		reg_sel = 1;
		reg_wr = w;
		reg_addr = a;
		reg_wdata = $random(seed);
		q.push_back(e);
	endtask
	task idle(input integer n);
		repeat (n)
		begin
			@(negedge mclk);
			reg_sel = 0;
		end
	endtask
	task rd2(input logic [31:0] s, input logic [31:0] m);
		acc(0, `SLCR_SYS_ADDR, {1'b0, SID, s[23:20], 4'hF, s[15:0]});
		acc(0, `SLCR_MEM_ADDR, {1'b0, m});
	endtask
	task dec(input logic [31:0] s, input logic [31:0] m);
		chk(cfg_valid, 1'b1);
		chk(clk_code_reserved, s[23:20] < 4'hD);
		chk(cpu0_present, s[15:14] == 2'h1);
		chk(cpu1_present, s[11:10] == 2'h1);
		chk(fref, m[28]);
		chk({spd_rsv, spd_edo}, {m[25:24] == 2'h2, m[25:24] == 2'h3});
		chk({rom_a, rom_b}, {m[22:20] == 3'h6, m[18:16] == 3'h6});
		chk(l2_rsv, m[15:12] >= 4'h2);
		chk({l2_en, l2_div_rsv}, {m[11:8] != 4'h0, m[11:8] > 4'h5});
		chk(mem_size_mb, 8'h10 << m[31:30]);
		chk(fl_abs, m[5:3] == 3'h7);
		chk(flash_a_size_mb,
			m[5:3] == 3'h7 ? 7'h0 : 7'h1 << m[5:3]);
	endtask
	// Results come back in order; pair each ack with the oldest note
	always @(negedge mclk)
		if (reg_ack === 1'b1)
		begin
			if (q.size() == 0)
				chk(40'h1, 40'h0);
			else
				chk({reg_err, reg_rdata}, q.pop_front());
		end
	initial
	begin
		#200000;
		n_fail++;
		close_out;
	end
	initial
	begin
		{ce, por_n, reg_sel, reg_wr, reg_addr, reg_wdata} = 0;
		{pd_sys, pd_mem, arst_n} = 0;
		ls = 32'hFFFFFFFF;
		lm = ls;
		repeat (10) @(negedge mclk);
		chk({reg_ack, reg_err, cfg_valid, reg_rdata}, 40'h0);
		arst_n = 1;
		ce = 1;
		rd2(ls, lm);
		idle(3);
		$display("reset test done");
		for (i = 0; i < 16; i++)
		begin
			c = i[3:0];
			r = $random(seed);
			ps = {r[31:24], c, r[19:16], c, ~c, r[7:0]};
			r = $random(seed);
			pm = {c[1:0], r[29:26], c[1:0], r[23], c[2:0], r[19], ~c[2:0],
				c, c, r[7:6], c[2:0], r[2:0]};
			pd_sys = ~ps;
			pd_mem = ~pm;
			idle(4);
			rd2(ls, lm);
			acc(1, `SLCR_SYS_ADDR, 33'h0);
			acc(1, `SLCR_MEM_ADDR, 33'h0);
			acc(0, 32'hFEF80408 + {26'h0, c, 2'h0}, {1'b1, 32'h0});
			rd2(ls, lm);
			idle(2);
			por_n = 0;
			idle(3);
			por_n = 1;
			idle(6);
			ls = ps;
			lm = pm;
			rd2(ls, lm);
			idle(2);
			dec(ls, lm);
		end
		$display("capture test done");
		ps = $random(seed);
		pd_sys = ~ps;
		ce = 0;
		// A strap pulse while frozen must not be seen
		por_n = 0;
		idle(3);
		por_n = 1;
		idle(2);
		ce = 1;
		rd2(ls, lm);
		idle(2);
		$display("enable test done");
		arst_n = 0;
		idle(2);
		chk({reg_ack, reg_err, cfg_valid}, 40'h0);
		arst_n = 1;
		idle(8);
		ls = ps;
		rd2(ls, lm);
		idle(3);
		chk(q.size(), 40'h0);
		$display("second reset test done");
		close_out;
	end
endmodule

bind slcr_top slcr_monitor #(.SYSTEM_ID(SYSTEM_ID)) u_mon (.mclk(mclk),
	.arst_n(arst_n), .ce(ce), .por_n(por_n), .reg_sel(reg_sel),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.reg_ack(reg_ack), .reg_err(reg_err), .cfg_valid(cfg_valid),
	.mem_size_mb(mem_size_mb), .flash_a_size_mb(flash_a_size_mb),
	.flash_a_absent(flash_a_absent));
